// file: include/sac_defines.vh
`ifndef SAC_DEFINES_VH
`define SAC_DEFINES_VH

// register offsets
`define SAC_OFF_CTRL      8'hb1
`define SAC_OFF_RES_HI    8'hb2
`define SAC_OFF_CLK_LO    8'hb3
`define SAC_OFF_REFSEL    8'haf
`define SAC_OFF_PINCFG    8'hae
`define SAC_OFF_IRQ       8'hb4

// conversion_control fields
`define SAC_CTRL_EN       7
`define SAC_CTRL_START    6
`define SAC_CTRL_EOC      5
`define SAC_CTRL_GATE     4
`define SAC_CTRL_RESET    8'h00

// clock_and_result_low fields
`define SAC_CLK_DIV1      6
`define SAC_CLK_DIV0      4
`define SAC_CLK_FIXED     5

// divider codes
`define SAC_DIV_16        2'b00
`define SAC_DIV_8         2'b01
`define SAC_DIV_1         2'b10
`define SAC_DIV_2         2'b11

// reference select fields
`define SAC_REF_EXT       7

// irq register fields
`define SAC_IRQ_FLAG      0
`define SAC_IRQ_EN        1
`define SAC_IRQ_RES8      2

// conversion lengths in quarter-rate periods
`define SAC_PERIODS_12    16
`define SAC_PERIODS_8     12
`define SAC_QUARTER       4

`endif

// file: src/sac_clk_div.v
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"

module sac_clk_div
(
  // system
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       run,
  input  wire [1:0] div_sel,
  // tick out
  output reg        tick
);

  reg  [3:0] cnt_r;
  wire [3:0] last;

  function [3:0] div_last;
    input [1:0] sel;
    begin
      case (sel)
        `SAC_DIV_16: div_last = 4'hf;
        `SAC_DIV_8:  div_last = 4'h7;
        `SAC_DIV_1:  div_last = 4'h0;
        default:     div_last = 4'h1;
      endcase
    end
  endfunction

  assign last = div_last(div_sel);

  // counter restarts with each conversion so every run has equal length
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
    end
    else if (cnt_r >= last)
    begin
      cnt_r <= 4'h0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: src/sac_seq.v
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"

module sac_seq
(
  // system
  input  wire        clk,
  input  wire        rst,
  // control
  input  wire        run,
  input  wire        tick,
  input  wire        res8,
  // converter sample
  input  wire [11:0] conv_code,
  // status
  output reg         done,
  output reg  [11:0] result
);

  // quarter-rate ticks: 4 conversion clocks each
  reg  [7:0] tcnt_r;
  wire [7:0] total;

  // macro products are 32-bit; only the low byte carries the tick count
  localparam [31:0] LEN_12 = `SAC_PERIODS_12 * `SAC_QUARTER;
  localparam [31:0] LEN_8  = `SAC_PERIODS_8 * `SAC_QUARTER;

  assign total = res8 ? LEN_8[7:0] : LEN_12[7:0];

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tcnt_r <= 8'h00;
      done   <= 1'b0;
      result <= 12'h000;
    end
    else if (!run)
    begin
      tcnt_r <= 8'h00;
      done   <= 1'b0;
    end
    else if (tick)
    begin
      if (tcnt_r == total - 8'h01)
      begin
        tcnt_r <= 8'h00;
        done   <= 1'b1;
        result <= res8 ? {conv_code[11:4], 4'h0} : conv_code;
      end
      else
      begin
        tcnt_r <= tcnt_r + 8'h01;
        done   <= 1'b0;
      end
    end
    else
      done <= 1'b0;
  end

endmodule
`default_nettype wire

// file: src/sac_top.v
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "sac_defines.vh"

module sac_top
(
  // system
  input  wire        clk,
  input  wire        rst,
  // register port
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  // analog converter side
  input  wire [11:0] conv_code,
  output reg  [5:0]  chan_connect,
  output wire        conv_power,
  output wire        conv_busy,
  output wire        ref_external,
  output wire [1:0]  ref_level,
  output wire [4:0]  pin_digital_off,
  // processor
  output wire        irq
);

  // highest valid channel code; codes above it connect nothing
  localparam [2:0] LAST_CHAN = 3'd5;

  // control register fields
  reg         en_r;
  reg         start_r;
  reg         eoc_r;
  reg         gate_r;
  reg  [2:0]  chan_r;
  reg         en_nxt;
  reg         start_nxt;
  reg         eoc_nxt;
  reg         gate_nxt;
  reg  [2:0]  chan_nxt;
  // divider, reference and pin configuration
  reg  [1:0]  div_r;
  reg         ext_ref_r;
  reg  [1:0]  lvl_r;
  reg  [4:0]  pincfg_r;
  reg  [1:0]  div_nxt;
  reg         ext_ref_nxt;
  reg  [1:0]  lvl_nxt;
  reg  [4:0]  pincfg_nxt;
  // interrupt flag, enable and resolution
  reg         irq_flag_r;
  reg         irq_en_r;
  reg         res8_r;
  reg         irq_flag_nxt;
  reg         irq_en_nxt;
  reg         res8_nxt;
  // read path
  reg  [7:0]  rdata_nxt;
  // decoded strobes and sequencer links
  wire        wr_ctrl;
  wire        wr_clk;
  wire        wr_ref;
  wire        wr_pin;
  wire        wr_irq;
  wire        run;
  wire        tick;
  wire        done;
  wire [11:0] result;

  function is_wr;
    input       w;
    input [7:0] a;
    input [7:0] off;
    begin
      is_wr = w && (a == off);
    end
  endfunction

  // one-hot source select; gate, power and code range must all agree
  function [5:0] chan_onehot;
    input       gate;
    input       pwr;
    input [2:0] code;
    begin
      chan_onehot = 6'h00;
      if (gate && pwr && code <= LAST_CHAN)
        chan_onehot[code] = 1'b1;
    end
  endfunction

  assign wr_ctrl = is_wr(wr, addr, `SAC_OFF_CTRL);
  assign wr_clk  = is_wr(wr, addr, `SAC_OFF_CLK_LO);
  assign wr_ref  = is_wr(wr, addr, `SAC_OFF_REFSEL);
  assign wr_pin  = is_wr(wr, addr, `SAC_OFF_PINCFG);
  assign wr_irq  = is_wr(wr, addr, `SAC_OFF_IRQ);

  assign run = en_r && start_r;

  sac_clk_div u_div
  (
    .clk     (clk),
    .rst     (rst),
    .run     (run),
    .div_sel (div_r),
    .tick    (tick)
  );

  sac_seq u_seq
  (
    .clk       (clk),
    .rst       (rst),
    .run       (run),
    .tick      (tick),
    .res8      (res8_r),
    .conv_code (conv_code),
    .done      (done),
    .result    (result)
  );

  // control register next state
  always @*
  begin
    en_nxt    = en_r;
    start_nxt = start_r;
    eoc_nxt   = eoc_r;
    gate_nxt  = gate_r;
    chan_nxt  = chan_r;
    if (wr_ctrl)
    begin
      en_nxt   = wdata[`SAC_CTRL_EN];
      gate_nxt = wdata[`SAC_CTRL_GATE];
      chan_nxt = wdata[2:0];
      // start written with enable low is dropped; a cleared start aborts
      start_nxt = wdata[`SAC_CTRL_START] && wdata[`SAC_CTRL_EN];
      if (wdata[`SAC_CTRL_START] && !start_r)
        eoc_nxt = 1'b0;
      else
        eoc_nxt = wdata[`SAC_CTRL_EOC];
    end
    else if (!en_r)
      start_nxt = 1'b0;
    // completion in the same cycle wins over a write to start or eoc
    if (done)
    begin
      start_nxt = 1'b0;
      eoc_nxt   = 1'b1;
    end
  end

  // configuration and interrupt next state
  always @*
  begin
    div_nxt      = div_r;
    ext_ref_nxt  = ext_ref_r;
    lvl_nxt      = lvl_r;
    pincfg_nxt   = pincfg_r;
    irq_en_nxt   = irq_en_r;
    res8_nxt     = res8_r;
    irq_flag_nxt = irq_flag_r;
    if (wr_clk)
      div_nxt = {wdata[`SAC_CLK_DIV1], wdata[`SAC_CLK_DIV0]};
    if (wr_ref)
    begin
      ext_ref_nxt = wdata[`SAC_REF_EXT];
      lvl_nxt     = wdata[1:0];
    end
    if (wr_pin)
      pincfg_nxt = wdata[4:0];
    if (wr_irq)
    begin
      irq_en_nxt = wdata[`SAC_IRQ_EN];
      res8_nxt   = wdata[`SAC_IRQ_RES8];
      // writing one to the flag does nothing; only zero clears it
      if (!wdata[`SAC_IRQ_FLAG])
        irq_flag_nxt = 1'b0;
    end
    // set wins over a software clear in the same cycle
    if (done)
      irq_flag_nxt = 1'b1;
  end

  // control register
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_r    <= 1'b0;
      start_r <= 1'b0;
      eoc_r   <= 1'b0;
      gate_r  <= 1'b0;
      chan_r  <= 3'h0;
    end
    else
    begin
      en_r    <= en_nxt;
      start_r <= start_nxt;
      eoc_r   <= eoc_nxt;
      gate_r  <= gate_nxt;
      chan_r  <= chan_nxt;
    end
  end

  // divider, reference and pin configuration registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_r     <= 2'b00;
      ext_ref_r <= 1'b0;
      lvl_r     <= 2'b00;
      pincfg_r  <= 5'h00;
    end
    else
    begin
      div_r     <= div_nxt;
      ext_ref_r <= ext_ref_nxt;
      lvl_r     <= lvl_nxt;
      pincfg_r  <= pincfg_nxt;
    end
  end

  // interrupt and resolution registers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_r <= 1'b0;
      irq_en_r   <= 1'b0;
      res8_r     <= 1'b0;
    end
    else
    begin
      irq_flag_r <= irq_flag_nxt;
      irq_en_r   <= irq_en_nxt;
      res8_r     <= res8_nxt;
    end
  end

  // source routing: one-hot, nothing when gate closed or powered down
  always @*
  begin
    chan_connect = chan_onehot(gate_r, en_r, chan_r);
  end

  assign conv_power      = en_r;
  assign conv_busy       = run;
  assign ref_external    = ext_ref_r;
  assign ref_level       = lvl_r;
  assign pin_digital_off = pincfg_r;
  assign irq             = irq_flag_r && irq_en_r;

  // read mux; result buffer ignores writes, unmapped offsets read zero
  always @*
  begin
    rdata_nxt = 8'h00;
    if (rd)
    begin
      case (addr)
        `SAC_OFF_CTRL:   rdata_nxt = {en_r, start_r, eoc_r, gate_r, 1'b0, chan_r};
        `SAC_OFF_RES_HI: rdata_nxt = result[11:4];
        `SAC_OFF_CLK_LO: rdata_nxt = {1'b0, div_r[1], 1'b1, div_r[0], result[3:0]};
        `SAC_OFF_REFSEL: rdata_nxt = {ext_ref_r, 5'h00, lvl_r};
        `SAC_OFF_PINCFG: rdata_nxt = {3'h0, pincfg_r};
        `SAC_OFF_IRQ:    rdata_nxt = {5'h00, res8_r, irq_en_r, irq_flag_r};
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data stand for one cycle after the strobe only
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= rdata_nxt;
  end

endmodule
`default_nettype wire

// file: dv/sac_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sac_checker
(
  // system
  input wire logic       clk,
  input wire logic       rst,
  // watched
  input wire logic       wr,
  input wire logic [5:0] chan_connect,
  input wire logic       conv_power,
  input wire logic       conv_busy,
  input wire logic [4:0] pin_digital_off,
  input wire logic       irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_ONE_SRC: assert property ($onehot0(chan_connect)) else $error("many sources");
  AST_OFF_ISO: assert property (!conv_power |-> chan_connect == 6'h00) else $error("source while off");
  AST_BUSY_EN: assert property (conv_busy |-> conv_power) else $error("busy while off");
  AST_BUSY_WR: assert property ($rose(conv_busy) |-> $past(wr)) else $error("start without write");
  AST_PWR_WR: assert property ($changed(conv_power) |-> $past(wr)) else $error("enable moved");
  AST_PIN_WR: assert property ($changed(pin_digital_off) |-> $past(wr)) else $error("pin config moved");
  AST_IRQ_HOLD: assert property (irq && !wr |=> irq) else $error("irq dropped");
  AST_IRQ_SET: assert property ($rose(irq) |-> $past(wr) || $fell(conv_busy)) else $error("irq unexpected");
endmodule
bind sac_top sac_checker u_chk (.clk(clk), .rst(rst), .wr(wr), .chan_connect(chan_connect),
  .conv_power(conv_power), .conv_busy(conv_busy), .pin_digital_off(pin_digital_off), .irq(irq));
`default_nettype wire

// file: dv/sac_analog_src.sv
`timescale 1ns/10ps
`default_nettype none
module sac_analog_src
#(
  parameter logic [71:0] LEVELS = 72'h0
)
(
  // system
  input  wire logic        clk,
  // converter side
  input  wire logic [5:0]  chan_connect,
  output logic      [11:0] conv_code
);
  logic   [11:0] idle_r = 12'h5a5;
  integer        i;
  // nothing connected: keep moving so a stale code never matches
  always @(posedge clk)
    idle_r <= ~idle_r;
  always @*
  begin
    conv_code = idle_r;
    for (i = 0; i < 6; i = i + 1)
      if (chan_connect[i])
        conv_code = LEVELS[i*12 +: 12];
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // channel five is a quarter of full scale
  localparam logic [71:0] LV = {12'h400, 12'h123, 12'ha5c, 12'h5a3, 12'hfff, 12'h000};
  // analog settling after enable: 100 us at 25 ns per cycle
  localparam integer SETTLE_CYC = 4000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [11:0] conv_code;
  logic [5:0]  chan_connect;
  logic        conv_power;
  logic        conv_busy;
  logic        ref_external;
  logic [1:0]  ref_level;
  logic [4:0]  pin_digital_off;
  logic        irq;
  integer      fails = 0;
  integer      comparisons = 0;
  integer      i;
  integer      n;
  integer      dv;
  always #12.5 clk = ~clk;
  sac_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .conv_code(conv_code), .chan_connect(chan_connect), .conv_power(conv_power), .conv_busy(conv_busy),
    .ref_external(ref_external), .ref_level(ref_level), .pin_digital_off(pin_digital_off), .irq(irq));
  sac_analog_src #(.LEVELS(LV)) u_src (.clk(clk), .chan_connect(chan_connect), .conv_code(conv_code));
  task complete_run;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task check(input logic [11:0] seen, input logic [11:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    end
  end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  end
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  end
  endtask
  // write control, then count busy cycles against the expected length
  task conv(input logic [7:0] ctl, input integer e);
  begin
    wr_reg(8'hb1, ctl);
    n = 0;
    while (conv_busy === 1'b1 && n < 3000)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    if (n >= 3000)
    begin
      fails = fails + 1;
      complete_run;
    end
    check(n >= e - 2 && n <= e + 2, 1'b1);
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'hb1, 8'h00);
    rd_chk(8'hb3, 8'h20);
    rd_chk(8'hae, 8'h00);
    rd_chk(8'h10, 8'h00);
    wr_reg(8'hae, 8'h15);
    check(pin_digital_off, 5'h15);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr_reg(8'haf, {i[0], 5'h00, i[1:0]});
      check({ref_external, ref_level}, {i[0], i[1:0]});
    end
    for (i = 0; i < 6; i = i + 1)
    begin
      wr_reg(8'hb1, 8'h90 | i[7:0]);
      check(chan_connect, 6'h01 << i);
      wr_reg(8'hb1, 8'h80 | i[7:0]);
      check(chan_connect, 6'h00);
    end
    check(conv_power, 1'b1);
    repeat (SETTLE_CYC) @(posedge clk);
    $display("test setup done");
    wr_reg(8'hb4, 8'h02);
    for (i = 0; i < 6; i = i + 1)
    begin
      dv = i[1] ? (i[0] ? 2 : 1) : (i[0] ? 8 : 16);
      wr_reg(8'hb3, {1'b0, i[1], 1'b0, i[0], 4'hf});
      conv(8'hd0 | i[7:0], 64 * dv);
      rd_chk(8'hb1, 8'hb0 | i[7:0]);
      rd_chk(8'hb2, LV[i*12+4 +: 8]);
      rd_chk(8'hb3, {1'b0, i[1], 1'b1, i[0], LV[i*12 +: 4]});
      check(irq, 1'b1);
      wr_reg(8'hb4, 8'h02);
      check(irq, 1'b0);
    end
    wr_reg(8'hb2, 8'hff);
    rd_chk(8'hb2, 8'h40);
    $display("test conversions done");
    wr_reg(8'hb4, 8'h04);
    wr_reg(8'hb3, 8'h40);
    conv(8'hd1, 48);
    check(irq, 1'b0);
    rd_chk(8'hb4, 8'h05);
    rd_chk(8'hb3, 8'h60);
    rd_chk(8'hb2, 8'hff);
    wr_reg(8'hb4, 8'h07);
    check(irq, 1'b1);
    conv(8'hd1, 48);
    check(irq, 1'b1);
    wr_reg(8'hb4, 8'h00);
    check(irq, 1'b0);
    $display("test irq done");
    wr_reg(8'hb3, 8'h00);
    conv(8'h40, 0);
    wr_reg(8'hb1, 8'h90);
    repeat (SETTLE_CYC) @(posedge clk);
    wr_reg(8'hb1, 8'hd0);
    repeat (10) @(posedge clk);
    conv(8'h90, 0);
    rd_chk(8'hb1, 8'h90);
    wr_reg(8'hb1, 8'hd0);
    repeat (10) @(posedge clk);
    conv(8'h10, 0);
    check(conv_power, 1'b0);
    rd_chk(8'hb1, 8'h10);
    rd_chk(8'hb4, 8'h00);
    $display("test abort done");
    complete_run;
  end
endmodule
`default_nettype wire
